// File: common/drrs_pkg.sv
// Shared constants and carrier types for the dynamic RAM refresh sequencer
package drrs_pkg;

  // ==========================================================================
  // Refresh timing
  // ==========================================================================
  localparam int unsigned CYCLES_PER_REFRESH = 36;   // Machine cycles between refreshes
  localparam logic [5:0] ARM_COUNT = 6'h23;          // Count 35 arms the request
  localparam logic [5:0] COUNT_AFTER_REFRESH = 6'h01; // First count clocked at refresh end
  localparam int unsigned COLUMN_BITS = 5;           // Column address width
  localparam int unsigned COLUMN_COUNT = 32;         // Columns to walk per full pass
  localparam int unsigned RETENTION_US = 2000;       // Cell retention limit, 2 msec
  localparam int unsigned REFRESH_PERIOD_NS = 57600; // 57.6 usec between refreshes
  localparam int unsigned FULL_PASS_US = 1850;       // 1.85 msec for all columns

  // ==========================================================================
  // Register map (word aligned byte addresses)
  // ==========================================================================
  localparam logic [7:0] REG_CONTROL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_REFRESH_COUNT = 8'h08;

  // Control register fields
  localparam int unsigned CTRL_ENABLE_BIT = 0;
  localparam logic CTRL_ENABLE_RESET = 1'b1;

  // Status register fields
  localparam int unsigned STAT_ACTIVE_BIT = 0;
  localparam int unsigned STAT_SUSPEND_BIT = 1;
  localparam int unsigned STAT_PENDING_BIT = 2;
  localparam int unsigned STAT_FETCH_BLOCK_BIT = 3;
  localparam int unsigned STAT_COLUMN_LSB = 8;
  localparam int unsigned STAT_COUNT_LSB = 16;

  // ==========================================================================
  // Carrier types
  // ==========================================================================
  // CPU machine-cycle timing strobes, raw from the generator or gated to the CPU
  typedef struct packed {
    logic cycle_open_strobe;
    logic early_execute_strobe;
    logic main_execute_strobe;
    logic transfer_phase_strobe;
    logic address_latch_strobe;
    logic aux_write_strobe;
    logic device_strobe_phase;
    logic cycle_end_strobe;
  } drrs_strobes_t;

  // Memory clock phases used to build the three refresh clocks
  typedef struct packed {
    logic reset_phase;
    logic phase_one;
    logic phase_two;
  } drrs_phases_t;

endpackage : drrs_pkg

// File: hw/drrs_refresh_sequencer.sv
// Refresh sequencer that steals one machine cycle for dynamic RAM refresh
`timescale 1ns/10ps

module drrs_refresh_sequencer #(
  parameter int unsigned COL_W = drrs_pkg::COLUMN_BITS
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire drrs_pkg::drrs_strobes_t raw_strobes,
  input wire logic cycle_tail_strobe,
  input wire logic fetch_latch_request,
  input wire drrs_pkg::drrs_phases_t ram_phases,
  input wire logic single_step,
  input wire logic halt_flag,
  input wire logic [COL_W-1:0] program_column,
  input wire logic [3:0] ram_write_select_in,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output drrs_pkg::drrs_strobes_t cpu_strobes,
  output logic fetch_latch_strobe,
  output logic ram_select_clear,
  output logic ram_select_gate,
  output logic [3:0] ram_write_select,
  output logic [COL_W-1:0] mem_column,
  output logic ram_clock_first,
  output logic ram_clock_second,
  output logic ram_clock_third,
  output logic ram_write_enable_n,
  output logic [31:0] reg_rdata
);

  // ==========================================================================
  // State
  // ==========================================================================
  logic [5:0] cycle_count_q;
  logic pending_q;
  logic refresh_q;
  logic suspend_q;
  logic fetch_block_q;
  logic [COL_W-1:0] column_q;
  logic enable_q;
  logic [15:0] refresh_total_q;
  logic resume_fetch_q;
  logic arm;
  logic open_armed;
  logic end_armed;
  logic end_refresh;
  logic tail_resume;

  // Decode of the arming count; gated by the software enable
  assign arm = enable_q && (cycle_count_q == drrs_pkg::ARM_COUNT);
  assign open_armed = raw_strobes.cycle_open_strobe && arm && !pending_q;
  assign end_armed = raw_strobes.cycle_end_strobe && pending_q;
  assign end_refresh = raw_strobes.cycle_end_strobe && refresh_q;
  assign tail_resume = cycle_tail_strobe && suspend_q && !refresh_q;

  // ==========================================================================
  // Machine-cycle counter
  // ==========================================================================
  // Raw end strobe is used, since the gated copy is dead during refresh
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cycle_count_q <= 6'h00;
    end else if (end_armed) begin
      cycle_count_q <= 6'h00;
    end else if (end_refresh) begin
      cycle_count_q <= drrs_pkg::COUNT_AFTER_REFRESH;
    end else if (raw_strobes.cycle_end_strobe && cycle_count_q != drrs_pkg::ARM_COUNT) begin
      cycle_count_q <= cycle_count_q + 6'h01;
    end
  end

  // ==========================================================================
  // Refresh request, active and suspension flags
  // ==========================================================================
  // Pending is caught at the opening strobe of the armed cycle
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pending_q <= 1'b0;
    end else if (open_armed) begin
      pending_q <= 1'b1;
    end else if (end_armed) begin
      pending_q <= 1'b0;
    end
  end

  // Refresh lasts exactly one stolen machine cycle
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      refresh_q <= 1'b0;
    end else if (end_armed) begin
      refresh_q <= 1'b1;
    end else if (end_refresh) begin
      refresh_q <= 1'b0;
    end
  end

  // Suspension outlives refresh until the following tail strobe
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      suspend_q <= 1'b0;
    end else if (end_armed) begin
      suspend_q <= 1'b1;
    end else if (tail_resume) begin
      suspend_q <= 1'b0;
    end
  end

  // Fetch stays blocked while single step or halt holds the CPU
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      fetch_block_q <= 1'b0;
    end else if (open_armed) begin
      fetch_block_q <= 1'b1;
    end else if (raw_strobes.main_execute_strobe && (refresh_q || !suspend_q)) begin
      fetch_block_q <= single_step || halt_flag;
    end
  end

  // ==========================================================================
  // Refresh column counter
  // ==========================================================================
  // Natural wrap of the five-bit counter gives the 32-column walk
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      column_q <= '0;
    end else if (end_refresh) begin
      column_q <= column_q + {{(COL_W-1){1'b0}}, 1'b1};
    end
  end

  // Running total of refreshes, visible to software
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      refresh_total_q <= 16'h0000;
    end else if (end_refresh) begin
      refresh_total_q <= refresh_total_q + 16'h0001;
    end
  end

  // ==========================================================================
  // Gated CPU timing strobes and fetch latch
  // ==========================================================================
  // Combinational gating keeps strobe timing unchanged outside suspension
  always_comb begin
    cpu_strobes = raw_strobes;
    if (suspend_q) begin
      cpu_strobes = '0;
    end
  end

  // Fetch latch strobe issued once at resume, or passed when not blocked
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      resume_fetch_q <= 1'b0;
    end else begin
      resume_fetch_q <= tail_resume && !fetch_block_q;
    end
  end

  assign fetch_latch_strobe = resume_fetch_q ||
                              (fetch_latch_request && !suspend_q && !fetch_block_q);

  // ==========================================================================
  // RAM side
  // ==========================================================================
  // Select latches cleared at the tail strobe that opens the refresh
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ram_select_clear <= 1'b0;
    end else begin
      ram_select_clear <= cycle_tail_strobe && refresh_q;
    end
  end

  // Column mux and forced select; every RAM sees the same column
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      mem_column <= '0;
      ram_select_gate <= 1'b0;
      ram_write_select <= 4'h0;
    end else begin
      mem_column <= refresh_q ? column_q : program_column;
      ram_select_gate <= refresh_q;
      ram_write_select <= refresh_q ? 4'h0 : ram_write_select_in;
    end
  end

  // Three refresh clocks, registered to keep them glitch free
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ram_clock_first <= 1'b0;
      ram_clock_second <= 1'b0;
      ram_clock_third <= 1'b0;
      ram_write_enable_n <= 1'b1;
    end else begin
      ram_clock_first <= refresh_q && ram_phases.reset_phase;
      ram_clock_second <= refresh_q && ram_phases.phase_one;
      ram_clock_third <= refresh_q && ram_phases.phase_two;
      ram_write_enable_n <= !(refresh_q && ram_phases.phase_two);
    end
  end

  // ==========================================================================
  // Register port
  // ==========================================================================
  // Disabling refresh risks data loss; it exists for bring-up only
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      enable_q <= drrs_pkg::CTRL_ENABLE_RESET;
    end else if (reg_write && reg_addr == drrs_pkg::REG_CONTROL) begin
      enable_q <= reg_wdata[drrs_pkg::CTRL_ENABLE_BIT];
    end
  end

  // Read data stands only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 32'h00000000;
    end else begin
      reg_rdata <= 32'h00000000;
      if (reg_read) begin
        case (reg_addr)
          drrs_pkg::REG_CONTROL: begin
            reg_rdata[drrs_pkg::CTRL_ENABLE_BIT] <= enable_q;
          end
          drrs_pkg::REG_STATUS: begin
            reg_rdata[drrs_pkg::STAT_ACTIVE_BIT] <= refresh_q;
            reg_rdata[drrs_pkg::STAT_SUSPEND_BIT] <= suspend_q;
            reg_rdata[drrs_pkg::STAT_PENDING_BIT] <= pending_q;
            reg_rdata[drrs_pkg::STAT_FETCH_BLOCK_BIT] <= fetch_block_q;
            reg_rdata[drrs_pkg::STAT_COLUMN_LSB +: COL_W] <= column_q;
            reg_rdata[drrs_pkg::STAT_COUNT_LSB +: 6] <= cycle_count_q;
          end
          drrs_pkg::REG_REFRESH_COUNT: begin
            reg_rdata[15:0] <= refresh_total_q;
          end
          default: begin
            reg_rdata <= 32'h00000000;
          end
        endcase
      end
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  property p_count_bound;
    @(posedge ref_clk) disable iff (!arst_n)
      cycle_count_q <= drrs_pkg::ARM_COUNT;
  endproperty
  a_count_bound: assert property (p_count_bound) else $error("cycle count passed arm value");

  property p_arm_open;
    @(posedge ref_clk) disable iff (!arst_n)
      (raw_strobes.cycle_open_strobe && enable_q && cycle_count_q == drrs_pkg::ARM_COUNT &&
       !pending_q)
      |=> (pending_q && fetch_block_q && !fetch_latch_strobe);
  endproperty
  a_arm_open: assert property (p_arm_open) else $error("armed open did not block fetch");

  property p_refresh_start;
    @(posedge ref_clk) disable iff (!arst_n)
      (raw_strobes.cycle_end_strobe && pending_q)
      |=> (refresh_q && suspend_q && cycle_count_q == 6'h00);
  endproperty
  a_refresh_start: assert property (p_refresh_start) else $error("refresh did not start");

  property p_column_source;
    @(posedge ref_clk) disable iff (!arst_n)
      refresh_q |=> (mem_column == $past(column_q) && ram_select_gate);
  endproperty
  a_column_source: assert property (p_column_source) else $error("column not from counter");

  property p_strobes_dead;
    @(posedge ref_clk) disable iff (!arst_n)
      (refresh_q || suspend_q) |-> (cpu_strobes == '0);
  endproperty
  a_strobes_dead: assert property (p_strobes_dead) else $error("strobe leaked in refresh");

  property p_select_clear;
    @(posedge ref_clk) disable iff (!arst_n)
      (cycle_tail_strobe && refresh_q) |=> ram_select_clear;
  endproperty
  a_select_clear: assert property (p_select_clear) else $error("select latches not cleared");

  property p_second_clock;
    @(posedge ref_clk) disable iff (!arst_n)
      (refresh_q && ram_phases.phase_one) |=> ram_clock_second;
  endproperty
  a_second_clock: assert property (p_second_clock) else $error("second clock missing");

  property p_third_write;
    @(posedge ref_clk) disable iff (!arst_n)
      ram_clock_third |-> (!ram_write_enable_n && ram_write_select == 4'h0);
  endproperty
  a_third_write: assert property (p_third_write) else $error("write enable wrong on third");

  property p_refresh_end;
    @(posedge ref_clk) disable iff (!arst_n)
      (raw_strobes.cycle_end_strobe && refresh_q)
      |=> (!refresh_q && cycle_count_q == drrs_pkg::COUNT_AFTER_REFRESH &&
           column_q == $past(column_q) + {{(COL_W-1){1'b0}}, 1'b1});
  endproperty
  a_refresh_end: assert property (p_refresh_end) else $error("refresh end step wrong");

  property p_resume;
    @(posedge ref_clk) disable iff (!arst_n)
      (cycle_tail_strobe && suspend_q && !refresh_q && !fetch_block_q)
      |=> (!suspend_q && fetch_latch_strobe);
  endproperty
  a_resume: assert property (p_resume) else $error("no resume or fetch after refresh");

endmodule : drrs_refresh_sequencer

// File: test/drrs_ram_model.sv
// Dynamic RAM bank model that records which columns received a full refresh
`timescale 1ns/10ps

// ============================================================================
// RAM bank model
// ============================================================================
module drrs_ram_model (
  input wire logic ref_clk,
  input wire logic ram_select_gate,
  input wire logic [4:0] mem_column,
  input wire logic ram_clock_first,
  input wire logic ram_clock_second,
  input wire logic ram_clock_third,
  input wire logic ram_write_enable_n,
  output logic [31:0] cols_done,
  output int n_done,
  output int n_bad
);
  logic [1:0] stage_q = 2'h0;
  logic [4:0] col_q = 5'h00;

  // Outputs start clean so the bench can count from time zero
  initial begin
    cols_done = '0;
    n_done = 0;
    n_bad = 0;
  end

  // A column counts only after three clocks in order on one column
  // Hazard: a third clock with write enable high would corrupt cells, so it is counted bad
  always @(posedge ref_clk) begin
    if (ram_clock_first && ram_select_gate) begin
      stage_q <= 2'h1;
      col_q <= mem_column;
    end else if (ram_clock_second && stage_q == 2'h1) begin
      stage_q <= 2'h2;
    end else if (ram_clock_third && stage_q == 2'h2) begin
      stage_q <= 2'h0;
      if (ram_write_enable_n !== 1'b0 || mem_column !== col_q) begin
        n_bad <= n_bad + 1;
      end else begin
        cols_done[col_q] <= 1'b1;
        n_done <= n_done + 1;
      end
    end
  end
endmodule : drrs_ram_model

// File: test/drrs_refresh_sequencer_bench.sv
// Self-checking bench for the refresh sequencer with a RAM bank model
`timescale 1ns/10ps

module drrs_refresh_sequencer_bench;
  // ==========================================================================
  // Stimulus and observed signals
  // ==========================================================================
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  drrs_pkg::drrs_strobes_t raw_strobes = '0;
  logic cycle_tail_strobe = 1'b0;
  logic fetch_latch_request = 1'b0;
  drrs_pkg::drrs_phases_t ram_phases = '0;
  logic single_step = 1'b0;
  logic halt_flag = 1'b0;
  logic [4:0] program_column = 5'h1F;
  logic [3:0] ram_write_select_in = 4'hF;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  drrs_pkg::drrs_strobes_t cpu_strobes;
  logic fetch_latch_strobe, ram_select_clear, ram_select_gate;
  logic [3:0] ram_write_select;
  logic [4:0] mem_column;
  logic ram_clock_first, ram_clock_second, ram_clock_third, ram_write_enable_n;
  logic [31:0] reg_rdata, rd_q, cols_done;
  logic fl_seen;
  int n_done, n_bad;
  int n_mismatch = 0;
  int tests_run = 0;

  // 50 MHz clock
  always #10 ref_clk = ~ref_clk;

  drrs_refresh_sequencer i_drrs_refresh_sequencer (
    .ref_clk(ref_clk), .arst_n(arst_n), .raw_strobes(raw_strobes),
    .cycle_tail_strobe(cycle_tail_strobe), .fetch_latch_request(fetch_latch_request),
    .ram_phases(ram_phases), .single_step(single_step), .halt_flag(halt_flag),
    .program_column(program_column), .ram_write_select_in(ram_write_select_in),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .cpu_strobes(cpu_strobes), .fetch_latch_strobe(fetch_latch_strobe),
    .ram_select_clear(ram_select_clear), .ram_select_gate(ram_select_gate),
    .ram_write_select(ram_write_select), .mem_column(mem_column),
    .ram_clock_first(ram_clock_first), .ram_clock_second(ram_clock_second),
    .ram_clock_third(ram_clock_third), .ram_write_enable_n(ram_write_enable_n),
    .reg_rdata(reg_rdata)
  );

  drrs_ram_model i_drrs_ram_model (
    .ref_clk(ref_clk), .ram_select_gate(ram_select_gate), .mem_column(mem_column),
    .ram_clock_first(ram_clock_first), .ram_clock_second(ram_clock_second),
    .ram_clock_third(ram_clock_third), .ram_write_enable_n(ram_write_enable_n),
    .cols_done(cols_done), .n_done(n_done), .n_bad(n_bad)
  );

  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic print_verdict();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Read data is valid only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge ref_clk);
    reg_read <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge ref_clk);
    reg_write <= 1'b0;
  endtask : wr

  // One pulse cycle then a quiet cycle; t is {request, tail, reset, phase one, phase two}
  // Registered answers are settled when this returns
  task automatic step(input logic [7:0] s, input logic [4:0] t, input logic sup);
    @(posedge ref_clk);
    raw_strobes <= s;
    {fetch_latch_request, cycle_tail_strobe, ram_phases} <= t;
    #1;
    chk("cpu_strobes", cpu_strobes, sup ? 8'h00 : s);
    fl_seen = fetch_latch_strobe;
    @(posedge ref_clk);
    raw_strobes <= '0;
    {fetch_latch_request, cycle_tail_strobe, ram_phases} <= 5'h00;
    #1;
  endtask : step

  // Normal machine cycle: open, execute, mid strobes, end, tail with fetch
  task automatic mcyc();
    step(8'h80, 5'h00, 1'b0);
    step(8'h20, 5'h00, 1'b0);
    step(8'h5E, 5'h00, 1'b0);
    step(8'h01, 5'h00, 1'b0);
    step(8'h00, 5'h18, 1'b0);
    chk("fetch_latch_strobe", fl_seen, 1'b1);
  endtask : mcyc

  // Armed cycle followed by the stolen refresh cycle at column col
  task automatic refr(input logic [4:0] col, input logic stp, input logic hlt);
    program_column <= ~col;
    rd(drrs_pkg::REG_STATUS, rd_q);
    chk("status", rd_q, {10'h0, drrs_pkg::ARM_COUNT, 3'h0, col, 8'h00});
    step(8'h80, 5'h00, 1'b0);
    rd(drrs_pkg::REG_STATUS, rd_q);
    chk("status", rd_q[3:0], 4'hC);
    step(8'h20, 5'h00, 1'b0);
    step(8'h01, 5'h00, 1'b0);
    rd(drrs_pkg::REG_STATUS, rd_q);
    chk("status", {rd_q[21:16], rd_q[1:0]}, 8'h03);
    chk("mem_column", mem_column, col);
    chk("ram_select_gate", ram_select_gate, 1'b1);
    step(8'h00, 5'h18, 1'b1);
    chk("ram_select_clear", ram_select_clear, 1'b1);
    chk("fetch_latch_strobe", fl_seen, 1'b0);
    single_step <= stp;
    halt_flag <= hlt;
    step(8'h80, 5'h00, 1'b1);
    step(8'h00, 5'h04, 1'b1);
    chk("clocks", {ram_clock_first, ram_clock_second, ram_clock_third}, 3'h4);
    step(8'h20, 5'h00, 1'b1);
    step(8'h5E, 5'h02, 1'b1);
    chk("clocks", {ram_clock_first, ram_clock_second, ram_clock_third}, 3'h2);
    step(8'h00, 5'h01, 1'b1);
    chk("clocks", {ram_clock_first, ram_clock_second, ram_clock_third,
                   ram_write_enable_n}, 4'h2);
    chk("ram_write_select", ram_write_select, 4'h0);
    step(8'h01, 5'h00, 1'b1);
    rd(drrs_pkg::REG_STATUS, rd_q);
    chk("status", {rd_q[21:16], rd_q[12:8], rd_q[0]}, {6'h01, col + 5'h01, 1'b0});
    step(8'h00, 5'h18, 1'b1);
    chk("fetch_latch_strobe", fetch_latch_strobe, !(stp || hlt));
    single_step <= 1'b0;
    halt_flag <= 1'b0;
  endtask : refr

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  // 33 periods so the column counter wraps once; step and halt take turns blocking
  initial begin
    repeat (16) @(posedge ref_clk);
    arst_n <= 1'b1;
    rd(drrs_pkg::REG_CONTROL, rd_q);
    chk("control", rd_q, 32'h1);
    wr(8'h0C, 32'hFFFFFFFF);
    rd(8'h0C, rd_q);
    chk("unmapped", rd_q, 32'h0);
    rd(drrs_pkg::REG_STATUS, rd_q);
    chk("status", rd_q, 32'h0);
    repeat (35) mcyc();
    chk("mem_column", mem_column, program_column);
    chk("ram_write_select", ram_write_select, 4'hF);
    // With refresh disabled the count parks at the arm value and fetch runs on
    wr(drrs_pkg::REG_CONTROL, 32'h0);
    rd(drrs_pkg::REG_CONTROL, rd_q);
    chk("control", rd_q, 32'h0);
    mcyc();
    rd(drrs_pkg::REG_STATUS, rd_q);
    chk("status", rd_q, {10'h0, drrs_pkg::ARM_COUNT, 16'h0000});
    wr(drrs_pkg::REG_CONTROL, 32'h1);
    for (int i = 0; i < 33; i++) begin
      refr(i[4:0], i % 3 == 1, i % 3 == 2);
      repeat (34) mcyc();
    end
    chk("cols_done", cols_done, 32'hFFFFFFFF);
    chk("n_done", n_done, 33);
    chk("n_bad", n_bad, 0);
    rd(drrs_pkg::REG_REFRESH_COUNT, rd_q);
    chk("refresh_total", rd_q[15:0], 16'h0021);
    print_verdict();
  end

  // Watchdog well beyond the expected run of about 12600 cycles
  initial begin
    repeat (60000) @(posedge ref_clk);
    n_mismatch++;
    print_verdict();
  end
endmodule : drrs_refresh_sequencer_bench
